//--- rtl/pxc_phy_cfg.sv
/*
  Expansion and vendor configuration registers of a 10/100 PHY, reached
  over a classic Wishbone slave, with the mode outputs they steer.
  Assumes status inputs come from PHY logic on i_core_clk; straps are pins.
*/
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pxc_regs.svh"

module pxc_phy_cfg
  import pxc_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // strap pins
  input  wire logic        i_coding_bypass_strap,
  input  wire logic        i_scrambler_bypass_strap,
  input  wire logic        i_alignment_bypass_strap,
  input  wire logic        i_repeater_node_strap,
  // negotiation status from the phy core
  input  wire logic        i_parallel_detect_fault,
  input  wire logic        i_page_received,
  input  wire logic        i_partner_next_page_able,
  input  wire logic        i_partner_negotiation_able,
  // line activity from the phy core
  input  wire logic        i_rx_active,
  input  wire logic        i_tx_active,
  input  wire logic        i_link_ok,
  input  wire logic        i_full_duplex,
  input  wire logic        i_speed_10,
  input  wire logic        i_rx_polarity,
  // mode outputs
  output logic             o_coding_bypass,
  output logic             o_scrambler_bypass,
  output logic             o_alignment_bypass,
  output logic             o_repeater_mode,
  output logic             o_media_tx,
  output logic             o_cable_utp,
  output logic             o_ref_clock_output_oe,
  output logic             o_link_good,
  output logic             o_carrier_sense,
  output logic             o_link_lamp,
  output logic             o_duplex_lamp,
  output logic             o_state_machine_reset,
  output logic             o_mgmt_preamble_suppress
);

  localparam logic [7:0] SMR_CYCLES = 8'(`PXC_SM_RESET_CYCLES);

  pxc_state_t s;
  pxc_state_t next_s;

  logic [3:0]  strap_sync;
  logic        req;
  logic        take;
  logic        hit_exp;
  logic        hit_cfg;
  logic        rd_exp;
  logic        wr_cfg;
  logic        wr_smr;
  logic [15:0] exp_word;
  logic [15:0] cfg_word;

  pxc_sync2 #(
    .WIDTH (4)
  ) u_strap_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({i_repeater_node_strap, i_alignment_bypass_strap,
                  i_scrambler_bypass_strap, i_coding_bypass_strap}),
    .o_sync     (strap_sync)
  );

  assign req     = i_wb_cyc & i_wb_stb;
  assign take    = req & ~s.ack;
  assign hit_exp = (i_wb_adr[7:2] == `PXC_IDX_EXPANSION);
  assign hit_cfg = (i_wb_adr[7:2] == `PXC_IDX_VENDOR);
  // read side effect at the edge where data is captured, not a cycle later,
  // so an event in between cannot slip past unreported
  assign rd_exp  = take & ~i_wb_we & hit_exp;
  assign wr_cfg  = req & s.ack & i_wb_we & hit_cfg;
  assign wr_smr  = wr_cfg & i_wb_sel[0] & i_wb_dat[`PXC_CFG_SM_RESET];

  always_comb begin
    exp_word = 16'h0000; // RULE_06
    exp_word[`PXC_EXP_FAULT]      = s.fault_latch;
    exp_word[`PXC_EXP_PARTNER_NP] = i_partner_next_page_able; // RULE_02
    exp_word[`PXC_EXP_LOCAL_NP]   = 1'b0; // RULE_03
    exp_word[`PXC_EXP_PAGE_RX]    = s.page_rx;
    exp_word[`PXC_EXP_PARTNER_AN] = i_partner_negotiation_able; // RULE_05
  end

  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[`PXC_CFG_CODING_BYP] = s.coding_byp;
    cfg_word[`PXC_CFG_SCR_BYP]    = s.scr_byp;
    cfg_word[`PXC_CFG_ALIGN_BYP]  = s.align_byp;
    cfg_word[`PXC_CFG_RSVD12]     = s.rsvd12;
    cfg_word[`PXC_CFG_REPEATER]   = s.repeater;
    cfg_word[`PXC_CFG_TX_MODE]    = s.tx_mode;
    cfg_word[`PXC_CFG_UTP]        = s.utp;
    cfg_word[`PXC_CFG_CLK_DIS]    = s.clk_dis;
    cfg_word[`PXC_CFG_FORCE_LINK] = s.force_link;
    cfg_word[`PXC_CFG_RSVD6]      = s.rsvd6;
    cfg_word[`PXC_CFG_LINK_MODE]  = s.link_mode;
    cfg_word[`PXC_CFG_DUP_MODE]   = s.dup_mode;
    cfg_word[`PXC_CFG_SM_RESET]   = (s.smr_cnt != 8'h00); // RULE_20
    cfg_word[`PXC_CFG_PRE_SUP]    = s.pre_sup;
  end

  always_comb begin
    next_s = s;
    // one wait state; ack drops the cycle after it was given
    next_s.ack = take;
    if (take) begin
      if (hit_exp) begin
        next_s.rdat = exp_word;
      end else if (hit_cfg) begin
        next_s.rdat = cfg_word;
      end else begin
        next_s.rdat = 16'h0000;
      end
    end

    // set wins over the clear-on-read
    next_s.fault_latch = i_parallel_detect_fault | (s.fault_latch & ~rd_exp); // RULE_01 RULE_22
    next_s.page_rx     = i_page_received | (s.page_rx & ~rd_exp); // RULE_04

    // straps read once the synchroniser holds real pin levels
    if (s.strap_wait != 3'h0) begin
      next_s.strap_wait = s.strap_wait - 3'h1;
    end
    if (s.strap_wait == 3'h1) begin
      next_s.coding_byp = strap_sync[0]; // RULE_13
      next_s.scr_byp    = strap_sync[1]; // RULE_13
      next_s.align_byp  = strap_sync[2]; // RULE_13
      next_s.repeater   = strap_sync[3]; // RULE_13
    end

    if (wr_cfg & i_wb_sel[1]) begin
      next_s.coding_byp = i_wb_dat[`PXC_CFG_CODING_BYP];
      next_s.scr_byp    = i_wb_dat[`PXC_CFG_SCR_BYP];
      next_s.align_byp  = i_wb_dat[`PXC_CFG_ALIGN_BYP];
      // stored as written; keeping it 0 is software's job
      next_s.rsvd12     = i_wb_dat[`PXC_CFG_RSVD12]; // RULE_10
      next_s.repeater   = i_wb_dat[`PXC_CFG_REPEATER];
      next_s.tx_mode    = i_wb_dat[`PXC_CFG_TX_MODE]; // RULE_14
      next_s.utp        = i_wb_dat[`PXC_CFG_UTP]; // RULE_15
      next_s.clk_dis    = i_wb_dat[`PXC_CFG_CLK_DIS];
    end
    if (wr_cfg & i_wb_sel[0]) begin
      next_s.force_link = i_wb_dat[`PXC_CFG_FORCE_LINK];
      next_s.rsvd6      = i_wb_dat[`PXC_CFG_RSVD6];
      next_s.link_mode  = i_wb_dat[`PXC_CFG_LINK_MODE];
      next_s.dup_mode   = i_wb_dat[`PXC_CFG_DUP_MODE];
      next_s.pre_sup    = i_wb_dat[`PXC_CFG_PRE_SUP]; // RULE_21
    end

    // a second request while the pulse runs is absorbed, not restarted
    if (s.smr_cnt != 8'h00) begin
      next_s.smr_cnt = s.smr_cnt - 8'h01;
    end else if (wr_smr) begin
      next_s.smr_cnt = SMR_CYCLES; // RULE_20
    end
    next_s.sm_reset = (next_s.smr_cnt != 8'h00); // RULE_20

    next_s.blink = s.blink + `PXC_BLINK_BITS'(1);

    // alignment bypass also takes out the coder and the scrambler
    next_s.code_byp_out = s.coding_byp | s.align_byp; // RULE_07 RULE_09
    next_s.scr_byp_out  = s.scr_byp | s.align_byp; // RULE_08 RULE_09
    next_s.ref_clk_oe   = ~s.clk_dis; // RULE_16
    next_s.link_good    = s.force_link | i_link_ok; // RULE_17
    if (s.repeater) begin
      next_s.crs = i_rx_active; // RULE_11
    end else begin
      next_s.crs = i_rx_active | i_tx_active; // RULE_12
    end
    if (s.link_mode) begin
      next_s.link_lamp = next_s.link_good &
                         ~((i_rx_active | i_tx_active) & s.blink[`PXC_BLINK_BITS-1]); // RULE_18
    end else begin
      next_s.link_lamp = next_s.link_good; // RULE_18
    end
    if (s.dup_mode & i_speed_10) begin
      next_s.duplex_lamp = i_rx_polarity; // RULE_19
    end else begin
      next_s.duplex_lamp = i_full_duplex; // RULE_19
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s            <= '0;
      s.rsvd12     <= `PXC_RST_RSVD12;
      s.tx_mode    <= `PXC_RST_TX_MODE; // RULE_14
      s.utp        <= `PXC_RST_UTP; // RULE_15
      s.clk_dis    <= `PXC_RST_CLK_DIS;
      s.force_link <= `PXC_RST_FORCE_LINK;
      s.rsvd6      <= `PXC_RST_RSVD6;
      s.link_mode  <= `PXC_RST_LINK_MODE;
      s.dup_mode   <= `PXC_RST_DUP_MODE;
      s.pre_sup    <= `PXC_RST_PRE_SUP; // RULE_21
      s.strap_wait <= `PXC_STRAP_WAIT;
    end else begin
      s <= next_s;
    end
  end

  assign o_wb_dat                 = {16'h0000, s.rdat};
  assign o_wb_ack                 = s.ack;
  assign o_coding_bypass          = s.code_byp_out;
  assign o_scrambler_bypass       = s.scr_byp_out;
  assign o_alignment_bypass       = s.align_byp;
  assign o_repeater_mode          = s.repeater;
  assign o_media_tx               = s.tx_mode;
  assign o_cable_utp              = s.utp;
  assign o_ref_clock_output_oe    = s.ref_clk_oe;
  assign o_link_good              = s.link_good;
  assign o_carrier_sense          = s.crs;
  assign o_link_lamp              = s.link_lamp;
  assign o_duplex_lamp            = s.duplex_lamp;
  assign o_state_machine_reset    = s.sm_reset;
  assign o_mgmt_preamble_suppress = s.pre_sup;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_fault_set;
    !$past(i_sys_rst) && i_parallel_detect_fault |=>
      s.fault_latch ##1 (s.fault_latch || $past(rd_exp));
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not latched"); // RULE_01

  property p_fault_hold;
    s.fault_latch && !rd_exp |=> s.fault_latch;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost"); // RULE_22

  property p_page_clear;
    rd_exp && !i_page_received |=> !s.page_rx && s.ack &&
                                   (o_wb_dat[1] == $past(s.page_rx));
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page flag read wrong"); // RULE_04

  property p_local_np;
    rd_exp |=> o_wb_ack && !o_wb_dat[2] && (o_wb_dat[31:5] == 27'h0);
  endproperty
  a_local_np: assert property (p_local_np) else $error("local next page bit set"); // RULE_03

  property p_partner_bits;
    rd_exp |=> o_wb_dat[3] == $past(i_partner_next_page_able) &&
               o_wb_dat[0] == $past(i_partner_negotiation_able);
  endproperty
  a_partner_bits: assert property (p_partner_bits) else $error("partner bits wrong"); // RULE_05

  property p_crs_repeater;
    s.repeater && !i_rx_active |=> !o_carrier_sense;
  endproperty
  a_crs_repeater: assert property (p_crs_repeater) else $error("crs from transmit"); // RULE_11

  property p_crs_node;
    !$past(i_sys_rst) && !s.repeater && (i_tx_active || i_rx_active) |=> o_carrier_sense;
  endproperty
  a_crs_node: assert property (p_crs_node) else $error("crs missing in node mode"); // RULE_12

  property p_align;
    s.align_byp |=> o_coding_bypass && o_scrambler_bypass;
  endproperty
  a_align: assert property (p_align) else $error("alignment bypass incomplete"); // RULE_09

  property p_force;
    s.force_link |=> o_link_good;
  endproperty
  a_force: assert property (p_force) else $error("forced link not reported"); // RULE_17

  property p_clk_dis;
    s.clk_dis |=> !o_ref_clock_output_oe;
  endproperty
  a_clk_dis: assert property (p_clk_dis) else $error("clock output not released"); // RULE_16

  property p_smr;
    wr_smr && s.smr_cnt == 8'h00 |=> o_state_machine_reset [*8] ##1 !o_state_machine_reset;
  endproperty
  a_smr: assert property (p_smr) else $error("state machine reset length wrong"); // RULE_20

  property p_strap;
    s.strap_wait == 3'h1 && !wr_cfg |=> s.repeater == $past(strap_sync[3]) &&
                                        s.align_byp == $past(strap_sync[2]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded"); // RULE_13

  // outputs still hold reset values one edge after release
  property p_page_set;
    !$past(i_sys_rst) && i_page_received |=> s.page_rx;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page flag not set"); // RULE_04

  property p_crs_rx;
    !$past(i_sys_rst) && i_rx_active |=> o_carrier_sense;
  endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("crs missing on receive"); // RULE_11

  property p_coding;
    s.coding_byp |=> o_coding_bypass;
  endproperty
  a_coding: assert property (p_coding) else $error("coding bypass not applied"); // RULE_07

  property p_scr;
    s.scr_byp |=> o_scrambler_bypass;
  endproperty
  a_scr: assert property (p_scr) else $error("scrambler bypass not applied"); // RULE_08

  property p_clk_en;
    !$past(i_sys_rst) && !s.clk_dis |=> o_ref_clock_output_oe;
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock output not driven"); // RULE_16

  property p_link_follow;
    !$past(i_sys_rst) && !s.force_link |=> o_link_good == $past(i_link_ok);
  endproperty
  a_link_follow: assert property (p_link_follow) else $error("link status wrong"); // RULE_17

  property p_lamp_steady;
    !s.link_mode |=> o_link_lamp == o_link_good;
  endproperty
  a_lamp_steady: assert property (p_lamp_steady) else $error("link lamp not link"); // RULE_18

  property p_duplex_full;
    !$past(i_sys_rst) && !(s.dup_mode && i_speed_10) |=>
      o_duplex_lamp == $past(i_full_duplex);
  endproperty
  a_duplex_full: assert property (p_duplex_full) else $error("duplex lamp wrong"); // RULE_19

  property p_duplex_pol;
    s.dup_mode && i_speed_10 |=> o_duplex_lamp == $past(i_rx_polarity);
  endproperty
  a_duplex_pol: assert property (p_duplex_pol) else $error("polarity lamp wrong"); // RULE_19

endmodule

`default_nettype wire

//--- rtl/pxc_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the
  auto-negotiation expansion and vendor configuration registers.
  Assumes it is included by bare name by the package and the main module.
*/
// What this block does
// RULE_01: parallel detection fault sets a sticky fault flag; reads 0 otherwise.
// RULE_02: read-only bit shows whether the link partner offers a next page.
// RULE_03: local next-page-able bit always reads 0.
// RULE_04: new page sets page-received flag; reading expansion register clears it.
// RULE_05: bit reads 1 when partner supports auto-negotiation, else 0.
// RULE_06: software writes zeros to reserved expansion bits and ignores them.
// RULE_07: coding bypass skips transmit 4B5B encoder and receive 5B4B decoder.
// RULE_08: scrambler bypass skips both transmit scrambler and receive descrambler.
// RULE_09: alignment bypass skips descrambler, alignment, decoding, encoder and scrambler.
// RULE_10: software keeps the reserved vendor configuration bit at 0.
// RULE_11: repeater mode asserts carrier sense from receive activity only.
// RULE_12: node mode asserts carrier sense from receive or transmit activity.
// RULE_13: repeater and three bypass bits load from straps at reset.
// RULE_14: media bit 1 selects TX, 0 selects FX; resets to 1.
// RULE_15: cable bit 1 means unshielded, 0 shielded pair; resets to 1.
// RULE_16: clock-output-disable bit 1 tri-states the 25 MHz clock output.
// RULE_17: force-link bit reports good 100 Mbit link regardless of line.
// RULE_18: link lamp mode 0 shows link; mode 1 also flashes on traffic.
// RULE_19: duplex lamp mode 1 shows 10 Mbit polarity; 0 shows full duplex.
// RULE_20: writing state-machine reset resets machines, bit self-clears when done.
// RULE_21: preamble suppression 1 accepts frames without preamble; resets to 0.
// RULE_22: fault flag holds until expansion read, clears unless fault persists.
`ifndef PXC_REGS_SVH
`define PXC_REGS_SVH

// register indices; byte address is four times the index
`define PXC_IDX_EXPANSION      6'h06
`define PXC_IDX_VENDOR         6'h10

// expansion register fields
`define PXC_EXP_FAULT          4
`define PXC_EXP_PARTNER_NP     3
`define PXC_EXP_LOCAL_NP       2
`define PXC_EXP_PAGE_RX        1
`define PXC_EXP_PARTNER_AN     0

// vendor configuration fields
`define PXC_CFG_CODING_BYP     15
`define PXC_CFG_SCR_BYP        14
`define PXC_CFG_ALIGN_BYP      13
`define PXC_CFG_RSVD12         12
`define PXC_CFG_REPEATER       11
`define PXC_CFG_TX_MODE        10
`define PXC_CFG_UTP            9
`define PXC_CFG_CLK_DIS        8
`define PXC_CFG_FORCE_LINK     7
`define PXC_CFG_RSVD6          6
`define PXC_CFG_LINK_MODE      5
`define PXC_CFG_DUP_MODE       4
`define PXC_CFG_SM_RESET       3
`define PXC_CFG_PRE_SUP        2

// reset values of fields not taken from straps
`define PXC_RST_RSVD12         1'b0
`define PXC_RST_TX_MODE        1'b1
`define PXC_RST_UTP            1'b1
`define PXC_RST_CLK_DIS        1'b0
`define PXC_RST_FORCE_LINK     1'b0
`define PXC_RST_RSVD6          1'b1
`define PXC_RST_LINK_MODE      1'b0
`define PXC_RST_DUP_MODE       1'b0
`define PXC_RST_PRE_SUP        1'b0

// timing
`define PXC_CLK_PERIOD_NS      40
`define PXC_SM_RESET_NS        320
`define PXC_SM_RESET_CYCLES    (`PXC_SM_RESET_NS / `PXC_CLK_PERIOD_NS)
`define PXC_STRAP_WAIT         3'h3
`define PXC_BLINK_BITS         22

`endif

//--- rtl/pxc_pkg.sv
/*
  Types of the expansion and vendor configuration register block.
  Assumes pxc_regs.svh is on the include path.
*/
`include "pxc_regs.svh"

package pxc_pkg;

  typedef struct packed {
    logic                        ack;
    logic [15:0]                 rdat;
    logic                        fault_latch;
    logic                        page_rx;
    logic                        coding_byp;
    logic                        scr_byp;
    logic                        align_byp;
    logic                        rsvd12;
    logic                        repeater;
    logic                        tx_mode;
    logic                        utp;
    logic                        clk_dis;
    logic                        force_link;
    logic                        rsvd6;
    logic                        link_mode;
    logic                        dup_mode;
    logic                        pre_sup;
    logic [7:0]                  smr_cnt;
    logic [2:0]                  strap_wait;
    logic [`PXC_BLINK_BITS-1:0]  blink;
    logic                        crs;
    logic                        link_good;
    logic                        link_lamp;
    logic                        duplex_lamp;
    logic                        ref_clk_oe;
    logic                        code_byp_out;
    logic                        scr_byp_out;
    logic                        sm_reset;
  } pxc_state_t;

endpackage

//--- rtl/pxc_sync2.sv
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the inputs are slow levels; no pulse capture.
*/
`timescale 1ns/1ps
`default_nettype none

module pxc_sync2 #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          meta[g]   <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta[g]   <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- test/pxc_mgmt_model.sv
/*
  Station management model: a classic Wishbone master with one transfer task.
  Assumes the testbench calls xfer hierarchically and the slave acks in time.
*/
`timescale 1ns/1ps
`default_nettype none

module pxc_mgmt_model (
  // clock
  input  wire logic        i_core_clk,
  // wishbone master
  input  wire logic        i_wb_ack,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_cyc,
  output logic             o_wb_stb,
  output logic             o_wb_we,
  output logic      [7:0]  o_wb_adr,
  output logic      [3:0]  o_wb_sel,
  output logic      [31:0] o_wb_dat
);
  initial begin
    o_wb_cyc = 1'b0;
    o_wb_stb = 1'b0;
    o_wb_we  = 1'b0;
    o_wb_adr = 8'h00;
    o_wb_sel = 4'h0;
    o_wb_dat = 32'h0;
  end

  // no wait limit here: the bench timeout ends a hung cycle
  task automatic xfer(input logic we, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s);
    logic [15:0] v;
    v = d;
    if (a == 8'h18) v = 16'h0000;
    if (a == 8'h40) v[12] = 1'b0;
    @(posedge i_core_clk);
    o_wb_cyc <= 1'b1;
    o_wb_stb <= 1'b1;
    o_wb_we  <= we;
    o_wb_adr <= a;
    o_wb_sel <= s;
    o_wb_dat <= {16'h0, v};
    @(posedge i_core_clk);
    while (i_wb_ack !== 1'b1) @(posedge i_core_clk);
    o_wb_cyc <= 1'b0;
    o_wb_stb <= 1'b0;
    o_wb_we  <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
/*
  Self-checking bench of the expansion and vendor configuration registers.
  Assumes pxc_phy_cfg and pxc_mgmt_model compile before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  strap = 4'h0;
  logic        flt = 1'b0, pg = 1'b0, pnp = 1'b0, pan = 1'b0;
  logic [5:0]  ln = 6'h0;
  wire         cyc, stb, we, ack;
  wire  [7:0]  adr;
  wire  [3:0]  sel;
  wire  [31:0] wdat, rdat;
  wire  [12:0] mo;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] cfg, d;
  int          error_cnt = 0, checked = 0, cyc_cnt = 0, n;
  integer      seed = 32'hfad5;

  always #20 clk = ~clk;

  pxc_mgmt_model u_mm (.i_core_clk(clk), .i_wb_ack(ack), .i_wb_dat(rdat),
    .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr),
    .o_wb_sel(sel), .o_wb_dat(wdat));

  pxc_phy_cfg u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_coding_bypass_strap(strap[3]), .i_scrambler_bypass_strap(strap[2]),
    .i_alignment_bypass_strap(strap[1]), .i_repeater_node_strap(strap[0]),
    .i_parallel_detect_fault(flt), .i_page_received(pg),
    .i_partner_next_page_able(pnp), .i_partner_negotiation_able(pan),
    .i_rx_active(ln[0]), .i_tx_active(ln[1]), .i_link_ok(ln[2]),
    .i_full_duplex(ln[3]), .i_speed_10(ln[4]), .i_rx_polarity(ln[5]),
    .o_coding_bypass(mo[12]), .o_scrambler_bypass(mo[11]),
    .o_alignment_bypass(mo[10]), .o_repeater_mode(mo[9]), .o_media_tx(mo[8]),
    .o_cable_utp(mo[7]), .o_ref_clock_output_oe(mo[6]), .o_link_good(mo[5]),
    .o_carrier_sense(mo[4]), .o_link_lamp(mo[3]), .o_duplex_lamp(mo[2]),
    .o_state_machine_reset(mo[1]), .o_mgmt_preamble_suppress(mo[0]));

  task automatic chk_d(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic chk_b(input logic got, input logic e);
    chk_d({31'h0, got}, {31'h0, e});
  endtask

  task summarize;
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // read data is judged where the ack shows, against the oldest note
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt >= 6000) begin
      error_cnt++;
      summarize();
    end else if (ack === 1'b1) begin
      if (exp_q.size() == 0) chk_d(rdat, 32'hdead);
      else if (msk_q[0] != 0) chk_d(rdat & msk_q[0], exp_q[0] & msk_q[0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
      if (msk_q.size() != 0) void'(msk_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    exp_q.push_back(32'h0);
    msk_q.push_back(32'h0);
    u_mm.xfer(1'b1, a, v, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_mm.xfer(1'b0, a, 16'h0, 4'h3);
  endtask

  // straps move with reset so they settle long before release
  task automatic do_reset();
    strap <= 4'($random(seed));
    rst   <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    cfg = {strap[3:1], 1'b0, strap[0], 3'b110, 2'b01, 6'h00};
    rd(8'h40, {16'h0, cfg}, 32'hffffffff);
    chk_b(mo[12], strap[3] | strap[1]);
    chk_b(mo[11], strap[2] | strap[1]);
    chk_b(mo[10], strap[1]);
    chk_b(mo[9], strap[0]);
    chk_b(mo[6], 1'b1);
    chk_b(mo[0], 1'b0);
  endtask

  initial begin
    do_reset();
    rd(8'h18, 32'h0, 32'hffff001f);
    @(posedge clk) {pnp, pan, flt, pg} <= 4'hf;
    @(posedge clk) {flt, pg} <= 2'b00;
    rd(8'h18, 32'h1b, 32'hffff001f);
    rd(8'h18, 32'h09, 32'hffff001f);
    {pnp, pan, flt} <= 3'b001;
    rd(8'h18, 32'h10, 32'hffff001f);
    rd(8'h18, 32'h10, 32'hffff001f);
    flt <= 1'b0;
    rd(8'h18, 32'h10, 32'hffff001f);
    rd(8'h18, 32'h00, 32'hffff001f);
    wr(8'h18, 16'hffff, 4'h3);
    rd(8'h18, 32'h00, 32'hffff001f);
    for (int i = 0; i < 10; i++) begin
      ln <= 6'($random(seed));
      d = 16'($random(seed));
      d[3] = 1'b0;
      cfg = d & 16'heffc;
      wr(8'h40, d, 4'h3);
      rd(8'h40, {16'h0, cfg}, 32'hffffffff);
      chk_b(mo[12], cfg[15] | cfg[13]);
      chk_b(mo[11], cfg[14] | cfg[13]);
      chk_b(mo[10], cfg[13]);
      chk_b(mo[9], cfg[11]);
      chk_b(mo[8], cfg[10]);
      chk_b(mo[7], cfg[9]);
      chk_b(mo[6], ~cfg[8]);
      chk_b(mo[5], cfg[7] | ln[2]);
      chk_b(mo[4], cfg[11] ? ln[0] : |ln[1:0]);
      if (!cfg[5] || !(|ln[1:0])) chk_b(mo[3], cfg[7] | ln[2]);
      chk_b(mo[2], (cfg[4] & ln[4]) ? ln[5] : ln[3]);
      chk_b(mo[0], cfg[2]);
    end
    wr(8'h40, 16'h00f4, 4'h1);
    cfg[7:0] = 8'hf4;
    wr(8'h40, 16'hff00, 4'h2);
    cfg[15:8] = 8'hef;
    rd(8'h40, {16'h0, cfg}, 32'hffffffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    wr(8'h24, 16'h1234, 4'h3);
    rd(8'h40, {16'h0, cfg}, 32'hffffffff);
    wr(8'h40, cfg | 16'h0008, 4'h1);
    n = 0;
    repeat (12) begin
      @(posedge clk);
      if (mo[1] === 1'b1) n++;
    end
    chk_d(32'(n), 32'd8);
    rd(8'h40, {16'h0, cfg}, 32'hffffffff);
    wr(8'h40, cfg | 16'h0008, 4'h1);
    rd(8'h40, {16'h0, cfg | 16'h0008}, 32'hffffffff);
    repeat (10) @(posedge clk);
    rd(8'h40, {16'h0, cfg}, 32'hffffffff);
    do_reset();
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule

`default_nettype wire
